//--- rtl/tqd_pkg.sv
package tqd_pkg;
   // ***********************************************
   // Bus and register map
   // ***********************************************
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 16;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 32'h50000200;
   localparam logic [ADDR_W-1:0] XCNT_OFS = 32'h50000202;
   localparam logic [ADDR_W-1:0] YCNT_OFS = 32'h50000204;
   localparam logic [ADDR_W-1:0] DIV_OFS = 32'h50000206;
   localparam logic [ADDR_W-1:0] ROUTE_OFS = 32'h50000208;
   localparam logic [ADDR_W-1:0] ZCNT_OFS = 32'h5000020a;
   // ***********************************************
   // Fields and reset values
   // ***********************************************
   localparam int unsigned THR_W = 7;
   localparam int unsigned THR_LSB = 3;
   localparam int unsigned THR_MSB = 9;
   localparam int unsigned STAT_BIT = 2;
   localparam int unsigned CLR_BIT = 1;
   localparam int unsigned MASK_BIT = 0;
   localparam logic [THR_W-1:0] THR_RST = 7'h02;
   localparam logic [THR_W-1:0] THR_MIN = 7'h01;
   localparam int unsigned DIV_W = 10;
   localparam logic [DIV_W-1:0] DIV_RST = 10'h000;
   localparam int unsigned SEL_W = 4;
   localparam int unsigned ROUTE_W = 12;
   localparam logic [ROUTE_W-1:0] ROUTE_RST = 12'h000;
   localparam int unsigned XSEL_LSB = 0;
   localparam int unsigned YSEL_LSB = 4;
   localparam int unsigned ZSEL_LSB = 8;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned EVT_W = 8;
   // ***********************************************
   // Pin pair select codes
   // ***********************************************
   localparam logic [SEL_W-1:0] SEL_P0_01 = 4'h1;
   localparam logic [SEL_W-1:0] SEL_P0_23 = 4'h2;
   localparam logic [SEL_W-1:0] SEL_P0_45 = 4'h3;
   localparam logic [SEL_W-1:0] SEL_P0_67 = 4'h4;
   localparam logic [SEL_W-1:0] SEL_P1_01 = 4'h5;
   localparam logic [SEL_W-1:0] SEL_P1_23 = 4'h6;
   localparam logic [SEL_W-1:0] SEL_P2_34 = 4'h7;
   localparam logic [SEL_W-1:0] SEL_P2_56 = 4'h8;
   localparam logic [SEL_W-1:0] SEL_P2_78 = 4'h9;
   localparam logic [SEL_W-1:0] SEL_P2_90 = 4'ha;
   localparam int unsigned P0_W = 8;
   localparam int unsigned P1_W = 6;
   localparam int unsigned P2_W = 10;
   localparam int unsigned PIN_W = P0_W + P1_W + P2_W;
   // ***********************************************
   // Types
   // ***********************************************
   typedef struct packed {
      logic [P2_W-1:0] p2;
      logic [P1_W-1:0] p1;
      logic [P0_W-1:0] p0;
   } tqd_pins_t;
   typedef struct packed {
      logic en;
      logic a;
      logic b;
   } tqd_quad_t;
   typedef enum logic [1:0] {
      TQD_IDLE = 2'b01,
      TQD_TRACK = 2'b10
   } tqd_state_t;
endpackage : tqd_pkg

//--- rtl/tqd_axis.sv
`timescale 1ns/1ps
module tqd_axis #(
   parameter int unsigned CNT_W = tqd_pkg::CNT_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input tqd_pkg::tqd_quad_t quad,
   output logic [CNT_W-1:0] count,
   output logic step
);
   // ***********************************************
   // Decoder state
   // ***********************************************
   localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};
   tqd_pkg::tqd_state_t state_q, state_d;
   logic [1:0] ab_q, ab_d;
   logic [CNT_W-1:0] count_q, count_d;
   logic step_q, step_d;

   always_comb begin
      state_d = state_q;
      ab_d = ab_q;
      count_d = count_q;
      step_d = 1'b0;
      if (!quad.en) begin
         state_d = tqd_pkg::TQD_IDLE;
         count_d = '0; // see [RULE5]
      end else if (tick) begin
         ab_d = {quad.a, quad.b};
         unique case (state_q)
            tqd_pkg::TQD_IDLE: begin
               state_d = tqd_pkg::TQD_TRACK;
            end
            tqd_pkg::TQD_TRACK: begin
               if ((ab_q[1] ^ quad.a) != (ab_q[0] ^ quad.b)) begin
                  step_d = 1'b1; // see [RULE10]
                  if (quad.a ^ ab_q[0]) begin
                     count_d = count_q + ONE;
                  end else begin
                     count_d = count_q - ONE;
                  end
               end
            end
            default: begin
               state_d = tqd_pkg::TQD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= tqd_pkg::TQD_IDLE;
         ab_q <= 2'h0;
         count_q <= '0;
         step_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ab_q <= ab_d;
         count_q <= count_d;
         step_q <= step_d;
      end
   end

   assign count = count_q;
   assign step = step_q;

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_zero_off;
      !quad.en |=> (count_q == '0);
   endproperty
   a_zero_off: assert property (p_zero_off) else $error("count not zero when off"); // see [RULE5]

   property p_step_unit;
      step_q |-> (CNT_W'(count_q - $past(count_q)) == ONE) ||
                 (CNT_W'($past(count_q) - count_q) == ONE);
   endproperty
   a_step_unit: assert property (p_step_unit) else $error("step not one unit"); // see [RULE10]

   property p_step_on_tick;
      step_q |-> $past(tick) && $past(quad.en);
   endproperty
   a_step_on_tick: assert property (p_step_on_tick) else $error("step without tick"); // see [RULE10]

   property p_hold_no_tick;
      quad.en && !tick |=> $stable(count_q) && !step_q;
   endproperty
   a_hold_no_tick: assert property (p_hold_no_tick) else $error("count moved off tick"); // see [RULE10]
endmodule : tqd_axis

//--- rtl/tqd_top.sv
`timescale 1ns/1ps
// Contract
// [RULE1] Seven-bit event threshold, reset two; zero acts as one.
// [RULE2] Read-only pending bit shows that the threshold was reached.
// [RULE3] Writing one to clear drops pending; clear bit returns to zero.
// [RULE4] Interrupt leaves only with enable set; enable resets to zero.
// [RULE5] Signed 16-bit count per axis, zero while axis has no pins.
// [RULE6] One logic tick every divider plus one input clock cycles.
// [RULE7] Axis 0 select codes one to ten pick pin pairs, others none.
// [RULE8] Axis 1 select uses the same pin pair mapping as axis 0.
// [RULE9] Axis 2 select uses the same pin pair mapping as axis 0.
// [RULE10] Each tick decode phases; count up one way, down the other.
// [RULE11] Axis 0 and 1 steps since clear set pending at threshold.
module tqd_top #(
   parameter int unsigned EVT_W = tqd_pkg::EVT_W
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [tqd_pkg::ADDR_W-1:0] ADDR,
   input wire logic [tqd_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [tqd_pkg::DATA_W-1:0] RDATA,
   input wire logic [tqd_pkg::P0_W-1:0] P0,
   input wire logic [tqd_pkg::P1_W-1:0] P1,
   input wire logic [tqd_pkg::P2_W-1:0] P2,
   output logic IRQ
);
   // ***********************************************
   // Pin pair routing
   // ***********************************************
   function automatic tqd_pkg::tqd_quad_t route_pick(
      input logic [tqd_pkg::SEL_W-1:0] sel,
      input tqd_pkg::tqd_pins_t p
   );
      tqd_pkg::tqd_quad_t q;
      q = '0;
      q.en = (sel >= tqd_pkg::SEL_P0_01) && (sel <= tqd_pkg::SEL_P2_90);
      case (sel)
         tqd_pkg::SEL_P0_01: {q.a, q.b} = {p.p0[0], p.p0[1]};
         tqd_pkg::SEL_P0_23: {q.a, q.b} = {p.p0[2], p.p0[3]};
         tqd_pkg::SEL_P0_45: {q.a, q.b} = {p.p0[4], p.p0[5]};
         tqd_pkg::SEL_P0_67: {q.a, q.b} = {p.p0[6], p.p0[7]};
         tqd_pkg::SEL_P1_01: {q.a, q.b} = {p.p1[0], p.p1[1]};
         tqd_pkg::SEL_P1_23: {q.a, q.b} = {p.p1[2], p.p1[3]};
         tqd_pkg::SEL_P2_34: {q.a, q.b} = {p.p2[3], p.p2[4]};
         tqd_pkg::SEL_P2_56: {q.a, q.b} = {p.p2[5], p.p2[6]};
         tqd_pkg::SEL_P2_78: {q.a, q.b} = {p.p2[7], p.p2[8]};
         tqd_pkg::SEL_P2_90: {q.a, q.b} = {p.p2[9], p.p2[0]};
         default: {q.a, q.b} = 2'h0;
      endcase
      return q;
   endfunction : route_pick

   // ***********************************************
   // Pin synchroniser
   // ***********************************************
   tqd_pkg::tqd_pins_t s1_q, s2_q, s3_q, filt_q, filt_d;

   always_comb begin
      filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         filt_q <= '0;
      end else begin
         s1_q <= {P2, P1, P0};
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
      end
   end

   // ***********************************************
   // Registers
   // ***********************************************
   logic [tqd_pkg::THR_W-1:0] thr_q, thr_d;
   logic mask_q, mask_d;
   logic clr_q, clr_d;
   logic [tqd_pkg::DIV_W-1:0] div_q, div_d;
   logic [tqd_pkg::ROUTE_W-1:0] route_q, route_d;
   logic [tqd_pkg::DATA_W-1:0] rdata_q, rdata_d;
   logic [tqd_pkg::CNT_W-1:0] x_count, y_count, z_count;
   logic pend_q, pend_d;
   logic clr_now;
   logic ctrl_wr;

   assign ctrl_wr = WR && (ADDR == tqd_pkg::CTRL_OFS);
   assign clr_now = ctrl_wr && WDATA[tqd_pkg::CLR_BIT];

   always_comb begin
      thr_d = thr_q;
      mask_d = mask_q;
      clr_d = 1'b0; // see [RULE3]
      div_d = div_q;
      route_d = route_q;
      if (ctrl_wr) begin
         thr_d = WDATA[tqd_pkg::THR_MSB:tqd_pkg::THR_LSB];
         mask_d = WDATA[tqd_pkg::MASK_BIT];
         clr_d = WDATA[tqd_pkg::CLR_BIT];
      end
      if (WR && (ADDR == tqd_pkg::DIV_OFS)) begin
         div_d = WDATA[tqd_pkg::DIV_W-1:0];
      end
      if (WR && (ADDR == tqd_pkg::ROUTE_OFS)) begin
         route_d = WDATA[tqd_pkg::ROUTE_W-1:0];
      end
      rdata_d = '0;
      if (RD) begin
         case (ADDR)
            tqd_pkg::CTRL_OFS: begin
               rdata_d[tqd_pkg::THR_MSB:tqd_pkg::THR_LSB] = thr_q;
               rdata_d[tqd_pkg::STAT_BIT] = pend_q; // see [RULE2]
               rdata_d[tqd_pkg::CLR_BIT] = clr_q;
               rdata_d[tqd_pkg::MASK_BIT] = mask_q;
            end
            tqd_pkg::XCNT_OFS: rdata_d = x_count;
            tqd_pkg::YCNT_OFS: rdata_d = y_count;
            tqd_pkg::ZCNT_OFS: rdata_d = z_count;
            tqd_pkg::DIV_OFS: rdata_d[tqd_pkg::DIV_W-1:0] = div_q;
            tqd_pkg::ROUTE_OFS: rdata_d[tqd_pkg::ROUTE_W-1:0] = route_q;
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         thr_q <= tqd_pkg::THR_RST;
         mask_q <= 1'b0;
         clr_q <= 1'b0;
         div_q <= tqd_pkg::DIV_RST;
         route_q <= tqd_pkg::ROUTE_RST;
         rdata_q <= '0;
      end else begin
         thr_q <= thr_d;
         mask_q <= mask_d;
         clr_q <= clr_d;
         div_q <= div_d;
         route_q <= route_d;
         rdata_q <= rdata_d;
      end
   end

   assign RDATA = rdata_q;

   // ***********************************************
   // Tick divider
   // ***********************************************
   logic [tqd_pkg::DIV_W-1:0] div_cnt_q, div_cnt_d;
   logic tick;

   assign tick = (div_cnt_q >= div_q); // see [RULE6]

   always_comb begin
      div_cnt_d = tick ? '0 : div_cnt_q + 10'h001;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         div_cnt_q <= '0;
      end else begin
         div_cnt_q <= div_cnt_d;
      end
   end

   // ***********************************************
   // Axes
   // ***********************************************
   tqd_pkg::tqd_quad_t x_quad, y_quad, z_quad;
   logic x_step, y_step;

   assign x_quad = route_pick(route_q[tqd_pkg::XSEL_LSB+:tqd_pkg::SEL_W], filt_q); // see [RULE7]
   assign y_quad = route_pick(route_q[tqd_pkg::YSEL_LSB+:tqd_pkg::SEL_W], filt_q); // see [RULE8]
   assign z_quad = route_pick(route_q[tqd_pkg::ZSEL_LSB+:tqd_pkg::SEL_W], filt_q); // see [RULE9]

   tqd_axis #(.CNT_W(tqd_pkg::CNT_W)) u_axis_x (
      .clk(CLK),
      .rst(RST),
      .tick(tick),
      .quad(x_quad),
      .count(x_count),
      .step(x_step)
   );

   tqd_axis #(.CNT_W(tqd_pkg::CNT_W)) u_axis_y (
      .clk(CLK),
      .rst(RST),
      .tick(tick),
      .quad(y_quad),
      .count(y_count),
      .step(y_step)
   );

   tqd_axis #(.CNT_W(tqd_pkg::CNT_W)) u_axis_z (
      .clk(CLK),
      .rst(RST),
      .tick(tick),
      .quad(z_quad),
      .count(z_count),
      .step()
   );

   // ***********************************************
   // Threshold events
   // ***********************************************
   logic [EVT_W-1:0] evt_q, evt_d, evt_base;
   logic [EVT_W:0] evt_sum;
   logic [1:0] steps;
   logic [tqd_pkg::THR_W-1:0] thr_eff;
   logic reach;

   assign thr_eff = (thr_q == '0) ? tqd_pkg::THR_MIN : thr_q; // see [RULE1]
   assign steps = {1'b0, x_step} + {1'b0, y_step};

   always_comb begin
      evt_base = clr_now ? '0 : evt_q;
      evt_sum = {1'b0, evt_base} + {{(EVT_W-1){1'b0}}, steps}; // see [RULE11]
      evt_d = evt_sum[EVT_W] ? '1 : evt_sum[EVT_W-1:0];
      reach = (evt_d >= EVT_W'(thr_eff)); // see [RULE11]
      pend_d = reach | (pend_q & ~clr_now); // see [RULE3]
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         evt_q <= '0;
         pend_q <= 1'b0;
      end else begin
         evt_q <= evt_d;
         pend_q <= pend_d;
      end
   end

   assign IRQ = pend_q & mask_q; // see [RULE4]

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   property p_thr_rise;
      $rose(pend_q) |-> (evt_q >= EVT_W'($past(thr_eff))) && ($past(thr_eff) != '0);
   endproperty
   a_thr_rise: assert property (p_thr_rise) else $error("pending below threshold"); // see [RULE1]

   property p_status_read;
      RD && (ADDR == tqd_pkg::CTRL_OFS) |=> RDATA[tqd_pkg::STAT_BIT] == $past(pend_q);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status bit wrong"); // see [RULE2]

   property p_clr_auto;
      clr_now ##1 !clr_now |=> !clr_q;
   endproperty
   a_clr_auto: assert property (p_clr_auto) else $error("clear bit stuck"); // see [RULE3]

   property p_clr_drop;
      clr_now && (steps == 2'h0) |=> !pend_q && (evt_q == '0);
   endproperty
   a_clr_drop: assert property (p_clr_drop) else $error("clear ignored"); // see [RULE3]

   property p_mask;
      !mask_q |-> !IRQ;
   endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt seen"); // see [RULE4]

   property p_div_gap;
      tick && (div_q != '0) && !WR |=> !tick;
   endproperty
   a_div_gap: assert property (p_div_gap) else $error("tick too soon"); // see [RULE6]

   // ***********************************************
   // Tick spacing reference
   // ***********************************************
   logic [tqd_pkg::DIV_W-1:0] since_q, since_d;
   logic div_new_q, div_new_d;

   always_comb begin
      since_d = tick ? '0 : since_q + 10'h001;
      div_new_d = (WR && (ADDR == tqd_pkg::DIV_OFS)) || (div_new_q && !tick);
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         since_q <= '0;
         div_new_q <= 1'b0;
      end else begin
         since_q <= since_d;
         div_new_q <= div_new_d;
      end
   end

   property p_div_period;
      !div_new_q |-> (tick == (since_q == div_q));
   endproperty
   a_div_period: assert property (p_div_period) else $error("tick spacing wrong"); // see [RULE6]

   property p_x_none;
      (route_q[tqd_pkg::XSEL_LSB+:tqd_pkg::SEL_W] > tqd_pkg::SEL_P2_90) |=> (x_count == '0);
   endproperty
   a_x_none: assert property (p_x_none) else $error("axis 0 counts unrouted"); // see [RULE7]

   property p_y_none;
      (route_q[tqd_pkg::YSEL_LSB+:tqd_pkg::SEL_W] == '0) |=> (y_count == '0);
   endproperty
   a_y_none: assert property (p_y_none) else $error("axis 1 counts unrouted"); // see [RULE8]

   property p_z_none;
      (route_q[tqd_pkg::ZSEL_LSB+:tqd_pkg::SEL_W] == '0) |=> (z_count == '0);
   endproperty
   a_z_none: assert property (p_z_none) else $error("axis 2 counts unrouted"); // see [RULE9]

   property p_evt_pend;
      (evt_d >= EVT_W'(thr_eff)) |=> pend_q;
   endproperty
   a_evt_pend: assert property (p_evt_pend) else $error("pending not set"); // see [RULE11]

   c_pend: cover property ($rose(pend_q));
   c_irq: cover property ($rose(IRQ));
   c_x_move: cover property (x_step ##1 (x_count != '0));
   c_clr_race: cover property (clr_now && (steps != 2'h0));
endmodule : tqd_top

//--- dv/tqd_enc_model.sv
`timescale 1ns/1ps
// *****
// Encoder model
// *****
module tqd_enc_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] sel,
   input wire logic step,
   input wire logic dn,
   output tqd_pkg::tqd_pins_t pins
);
   logic [1:0] ph_q;
   logic [1:0] ph_d;
   logic noise_q;
   logic noise_d;
   logic a;
   logic b;
   // Gray phase walk, A leads B going up
   always_comb begin
      ph_d = ph_q;
      noise_d = ~noise_q;
      if (step) begin
         ph_d = dn ? ph_q - 2'h1 : ph_q + 2'h1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_q <= 2'h0;
         noise_q <= 1'b0;
      end else begin
         ph_q <= ph_d;
         noise_q <= noise_d;
      end
   end
   assign a = ph_q[1] ^ ph_q[0];
   assign b = ph_q[1];
   // Unused pins flip every cycle
   always_comb begin
      pins = {tqd_pkg::PIN_W{noise_q}};
      case (sel)
         4'h1, 4'h2, 4'h3, 4'h4: begin
            pins.p0[2*sel-2] = a;
            pins.p0[2*sel-1] = b;
         end
         4'h5, 4'h6: begin
            pins.p1[2*sel-10] = a;
            pins.p1[2*sel-9] = b;
         end
         4'h7, 4'h8, 4'h9: begin
            pins.p2[2*sel-11] = a;
            pins.p2[2*sel-10] = b;
         end
         4'ha: begin
            pins.p2[9] = a;
            pins.p2[0] = b;
         end
         default: begin
         end
      endcase
   end
endmodule : tqd_enc_model

//--- dv/test_three_axis_quadrature_decoder.sv
`timescale 1ns/1ps
module test_three_axis_quadrature_decoder;
   logic CLK;
   logic RST;
   logic [31:0] ADDR;
   logic [15:0] WDATA;
   logic WR;
   logic RD;
   logic [15:0] RDATA;
   logic IRQ;
   logic [3:0] sel;
   logic step;
   logic dn;
   logic [15:0] e;
   tqd_pkg::tqd_pins_t pins;
   int miscompares;
   int checks;

   tqd_top dut (
      .CLK(CLK),
      .RST(RST),
      .ADDR(ADDR),
      .WDATA(WDATA),
      .WR(WR),
      .RD(RD),
      .RDATA(RDATA),
      .P0(pins.p0),
      .P1(pins.p1),
      .P2(pins.p2),
      .IRQ(IRQ)
   );
   tqd_enc_model enc (
      .clk(CLK),
      .rst(RST),
      .sel(sel),
      .step(step),
      .dn(dn),
      .pins(pins)
   );
   // *****
   // Tasks
   // *****
   task automatic results();
      if (miscompares == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [31:0] a, input logic [15:0] exp, input string n);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      chk(n, RDATA, exp);
   endtask : rdchk
   task automatic mv(input logic d, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge CLK);
         step <= 1'b1;
         dn <= d;
         @(posedge CLK);
         step <= 1'b0;
         repeat (gap) @(posedge CLK);
      end
   endtask : mv
   task automatic irqchk(input logic exp);
      #1;
      chk("irq", {15'h0000, IRQ}, {15'h0000, exp});
   endtask : irqchk
   // *****
   // Clock and watchdog
   // *****
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   initial begin
      repeat (60000) @(posedge CLK);
      miscompares++;
      results();
   end
   // *****
   // Main sequence
   // *****
   initial begin
      RST = 1'b1;
      ADDR = '0;
      WDATA = '0;
      WR = 1'b0;
      RD = 1'b0;
      sel = 4'h0;
      step = 1'b0;
      dn = 1'b0;
      miscompares = 0;
      checks = 0;
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      rdchk(tqd_pkg::CTRL_OFS, 16'h0010, "ctrl");
      rdchk(tqd_pkg::DIV_OFS, 16'h0000, "div");
      rdchk(tqd_pkg::ROUTE_OFS, 16'h0000, "route");
      irqchk(1'b0);
      wr(tqd_pkg::XCNT_OFS, 16'h1234);
      rdchk(tqd_pkg::XCNT_OFS, 16'h0000, "xcnt");
      wr(32'h50000210, 16'hffff);
      rdchk(32'h50000210, 16'h0000, "unmapped");
      wr(tqd_pkg::DIV_OFS, 16'hffff);
      rdchk(tqd_pkg::DIV_OFS, 16'h03ff, "div");
      wr(tqd_pkg::CTRL_OFS, 16'hfffc);
      rdchk(tqd_pkg::CTRL_OFS, 16'h03f8, "ctrl");
      wr(tqd_pkg::DIV_OFS, 16'h0000);
      // Select codes one to eleven on all three axes
      for (int c = 1; c < 12; c++) begin
         sel <= c[3:0];
         wr(tqd_pkg::ROUTE_OFS, {4'h0, c[3:0], c[3:0], c[3:0]});
         repeat (8) @(posedge CLK);
         mv(c[0], 4, 6);
         e = (c > 10) ? 16'h0000 : (c[0] ? 16'hfffc : 16'h0004);
         rdchk(tqd_pkg::XCNT_OFS, e, "xcnt");
         rdchk(tqd_pkg::YCNT_OFS, e, "ycnt");
         rdchk(tqd_pkg::ZCNT_OFS, e, "zcnt");
         wr(tqd_pkg::ROUTE_OFS, 16'h0000);
         rdchk(tqd_pkg::XCNT_OFS, 16'h0000, "xcnt");
      end
      // Threshold, clear and enable
      sel <= 4'h1;
      wr(tqd_pkg::ROUTE_OFS, 16'h0001);
      repeat (8) @(posedge CLK);
      wr(tqd_pkg::CTRL_OFS, 16'h0003);
      rdchk(tqd_pkg::CTRL_OFS, 16'h0001, "ctrl");
      irqchk(1'b0);
      mv(1'b0, 1, 6);
      irqchk(1'b1);
      rdchk(tqd_pkg::CTRL_OFS, 16'h0005, "ctrl");
      wr(tqd_pkg::CTRL_OFS, 16'h0002);
      rdchk(tqd_pkg::CTRL_OFS, 16'h0000, "ctrl");
      mv(1'b0, 1, 6);
      rdchk(tqd_pkg::CTRL_OFS, 16'h0004, "ctrl");
      irqchk(1'b0);
      wr(tqd_pkg::ROUTE_OFS, 16'h0011);
      repeat (8) @(posedge CLK);
      wr(tqd_pkg::CTRL_OFS, 16'h001b);
      mv(1'b1, 1, 6);
      irqchk(1'b0);
      mv(1'b1, 1, 6);
      irqchk(1'b1);
      wr(tqd_pkg::ROUTE_OFS, 16'h0100);
      repeat (8) @(posedge CLK);
      wr(tqd_pkg::CTRL_OFS, 16'h000b);
      mv(1'b0, 2, 6);
      irqchk(1'b0);
      rdchk(tqd_pkg::ZCNT_OFS, 16'h0002, "zcnt");
      // Tick period: 16-cycle phase rotation seen every 16 or every 4 cycles
      wr(tqd_pkg::ROUTE_OFS, 16'h0000);
      wr(tqd_pkg::DIV_OFS, 16'h000f);
      wr(tqd_pkg::ROUTE_OFS, 16'h0001);
      repeat (40) @(posedge CLK);
      mv(1'b0, 32, 2);
      repeat (40) @(posedge CLK);
      rdchk(tqd_pkg::XCNT_OFS, 16'h0000, "xcnt");
      wr(tqd_pkg::ROUTE_OFS, 16'h0000);
      wr(tqd_pkg::DIV_OFS, 16'h0003);
      wr(tqd_pkg::ROUTE_OFS, 16'h0001);
      repeat (40) @(posedge CLK);
      mv(1'b0, 32, 2);
      repeat (40) @(posedge CLK);
      rdchk(tqd_pkg::XCNT_OFS, 16'h0020, "xcnt");
      results();
   end
endmodule : test_three_axis_quadrature_decoder
